//--- core/api_device_end.sv
// Device end: parses request frames and answers with response or loopback frames.
`timescale 1ns/1ps
// Functional notes
// - Frame: delimiter, 16-bit length, body, checksum.
// - Type byte 0x17 means remote setting request.
// - Frame identifier zero suppresses the response.
// - Response type 0x97 echoes frame identifier.
// - Host places 64-bit target address.
// - Host fills reserved field with 0xFFFE.
// - Option bit 0 disables acknowledgement.
// - Option bit 1 applies now, else pending.
// - Host zeroes reserved option bits.
// - Option bit 4 sends securely.
// - Host places two-character command name.
// - No parameter bytes means query, return value.
// - Parameter bytes are the new value.
// - Checksum is 0xFF minus body sum.
// - Host should avoid broadcast setting requests.
// - Loopback cluster 0x0012 echoes packet back.
module api_device_end #(
  parameter int NSET = 4,
  parameter int MAXP = 16,
  parameter int FIFO_DEPTH = 16,
  parameter logic [63:0] OWN_ADDR = 64'h0000_0000_0000_0001
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic srst_i,
  // Link to the host.
  api_link_if.device link,
  // Local configuration.
  input wire logic rx_frame_format_option_i,
  // Setting store and transmission status.
  output logic [NSET*8-1:0] setting_o,
  output logic ack_disable_o,
  output logic secure_o,
  output logic req_done_o,
  output logic bad_frame_o
);
  localparam int IW = $clog2(NSET);
  typedef enum {P_DELIM, P_LENH, P_LENL, P_BODY, P_SUM, P_EXEC, P_SEND} pstate_t;

  pstate_t st_r;
  logic rx_rdy_r;
  logic [15:0] len_r;
  logic [15:0] pos_r;
  logic [7:0] sum_r;
  logic [7:0] type_r;
  logic [7:0] fid_r;
  logic [7:0] opt_r;
  logic [15:0] cmd_r;
  logic [15:0] cluster_r;
  logic [7:0] pbuf [MAXP];
  logic [7:0] np_r;
  logic [7:0] last_r;
  logic [7:0] set_r [NSET];
  logic [7:0] pend_val_r [NSET];
  logic [NSET-1:0] pend_r;
  logic [7:0] tx_idx_r;
  logic [7:0] tx_sum_r;
  logic [7:0] tx_byte;
  logic [15:0] tx_len;
  logic tx_last;
  logic take;
  logic sum_ok;
  logic is_req;
  logic is_loop;
  logic send;
  logic f_valid;
  logic f_ready;
  logic [IW-1:0] idx;

  assign link.h2d_ready = rx_rdy_r;
  assign take = link.h2d_valid && rx_rdy_r;
  assign sum_ok = 8'(sum_r + link.h2d_data) == rsr_pkg::SUM_BASE;
  assign is_req = type_r == rsr_pkg::TYPE_REMOTE_REQ;
  assign is_loop = type_r == rsr_pkg::TYPE_EXPLICIT && cluster_r == rsr_pkg::LOOP_CLUSTER;
  assign send = (is_req && fid_r != 8'h00) || is_loop;
  assign idx = cmd_r[IW-1:0];

  ////////////////////////////////////////////////////////////////////////////////
  // Frame framing and sequencing.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_r <= P_DELIM;
      rx_rdy_r <= 1'b1;
      len_r <= '0;
      pos_r <= '0;
      bad_frame_o <= 1'b0;
    end else begin
      bad_frame_o <= 1'b0;
      case (st_r)
        P_DELIM: begin
          if (take && link.h2d_data == rsr_pkg::START_DELIM) begin
            st_r <= P_LENH;
          end
        end
        P_LENH: begin
          if (take) begin
            len_r[15:8] <= link.h2d_data;
            st_r <= P_LENL;
          end
        end
        P_LENL: begin
          if (take) begin
            len_r[7:0] <= link.h2d_data;
            pos_r <= rsr_pkg::OFS_TYPE;
            st_r <= ({len_r[15:8], link.h2d_data} == 16'h0000) ? P_SUM : P_BODY;
          end
        end
        P_BODY: begin
          if (take) begin
            pos_r <= pos_r + 16'h0001;
            if (pos_r == len_r + 16'h0002) begin
              st_r <= P_SUM;
            end
          end
        end
        P_SUM: begin
          if (take) begin
            if (sum_ok) begin
              st_r <= P_EXEC;
              rx_rdy_r <= 1'b0;
            end else begin
              st_r <= P_DELIM;
              bad_frame_o <= 1'b1;
            end
          end
        end
        P_EXEC: begin
          if (send) begin
            st_r <= P_SEND;
          end else begin
            st_r <= P_DELIM;
            rx_rdy_r <= 1'b1;
          end
        end
        P_SEND: begin
          if (f_valid && f_ready && tx_last) begin
            st_r <= P_DELIM;
            rx_rdy_r <= 1'b1;
          end
        end
        default: begin
          st_r <= P_DELIM;
          rx_rdy_r <= 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Body sum and field capture.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sum_r <= '0;
    end else if (st_r == P_LENL && take) begin
      sum_r <= '0;
    end else if (st_r == P_BODY && take) begin
      sum_r <= sum_r + link.h2d_data;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      type_r <= '0;
      fid_r <= '0;
      opt_r <= '0;
      cmd_r <= '0;
      cluster_r <= '0;
      np_r <= '0;
      last_r <= '0;
    end else if (st_r == P_LENL && take) begin
      type_r <= '0;
      np_r <= '0;
    end else if (st_r == P_BODY && take) begin
      if (pos_r == rsr_pkg::OFS_TYPE) begin
        type_r <= link.h2d_data;
      end
      if (pos_r == rsr_pkg::OFS_FID) begin
        fid_r <= link.h2d_data;
      end
      if (pos_r == rsr_pkg::OFS_OPT) begin
        opt_r <= link.h2d_data;
      end
      if (pos_r == rsr_pkg::OFS_CMD) begin
        cmd_r[15:8] <= link.h2d_data;
      end
      if (pos_r == rsr_pkg::OFS_CMD + 16'h0001) begin
        cmd_r[7:0] <= link.h2d_data;
      end
      if (pos_r == rsr_pkg::OFS_CLUSTER) begin
        cluster_r[15:8] <= link.h2d_data;
      end
      if (pos_r == rsr_pkg::OFS_CLUSTER + 16'h0001) begin
        cluster_r[7:0] <= link.h2d_data;
      end
      // Bytes beyond MAXP are summed and reach last_r but not pbuf, so long loopback payloads are cut short.
      if ((is_req && pos_r >= rsr_pkg::OFS_PARAM)
          || (type_r == rsr_pkg::TYPE_EXPLICIT && pos_r >= rsr_pkg::OFS_PAYLOAD)) begin
        last_r <= link.h2d_data;
        if (np_r < 8'(MAXP)) begin
          np_r <= np_r + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (st_r == P_BODY && take && np_r < 8'(MAXP)) begin
      pbuf[np_r[$clog2(MAXP)-1:0]] <= link.h2d_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Setting store: immediate or pending changes.
  genvar gi;
  generate
    for (gi = 0; gi < NSET; gi++) begin : g_set
      logic hit;
      logic commit_all;
      assign hit = st_r == P_EXEC && is_req && np_r != 8'h00
                   && cmd_r != rsr_pkg::COMMIT_CMD && idx == IW'(gi);
      assign commit_all = st_r == P_EXEC && is_req
                          && (cmd_r == rsr_pkg::COMMIT_CMD
                              || (np_r != 8'h00 && opt_r[rsr_pkg::OPT_APPLY_BIT]));
      assign setting_o[gi*8 +: 8] = set_r[gi];
      always_ff @(posedge clk_i) begin
        if (srst_i) begin
          set_r[gi] <= '0;
          pend_val_r[gi] <= '0;
          pend_r[gi] <= 1'b0;
        end else if (hit && opt_r[rsr_pkg::OPT_APPLY_BIT]) begin
          set_r[gi] <= last_r;
          pend_r[gi] <= 1'b0;
        end else if (hit) begin
          pend_val_r[gi] <= last_r;
          pend_r[gi] <= 1'b1;
        end else if (commit_all && pend_r[gi]) begin
          set_r[gi] <= pend_val_r[gi];
          pend_r[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ack_disable_o <= 1'b0;
      secure_o <= 1'b0;
      req_done_o <= 1'b0;
    end else begin
      req_done_o <= st_r == P_EXEC && is_req;
      if (st_r == P_EXEC && is_req) begin
        ack_disable_o <= opt_r[rsr_pkg::OPT_NOACK_BIT];
        secure_o <= opt_r[rsr_pkg::OPT_SECURE_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Answer builder; the FIFO absorbs link stalls so the builder rarely waits.
  always_comb begin
    logic [7:0] k;
    k = tx_idx_r - 8'h03;
    tx_len = is_req ? rsr_pkg::HDR_LEN + {15'h0000, np_r == 8'h00} : {8'h00, np_r} + 16'h0001;
    tx_last = {8'h00, tx_idx_r} == tx_len + 16'h0003;
    tx_byte = 8'h00;
    if (tx_idx_r == 8'h00) begin
      tx_byte = rsr_pkg::START_DELIM;
    end else if (tx_idx_r == 8'h01) begin
      tx_byte = tx_len[15:8];
    end else if (tx_idx_r == 8'h02) begin
      tx_byte = tx_len[7:0];
    end else if (tx_last) begin
      tx_byte = rsr_pkg::SUM_BASE - tx_sum_r;
    end else if (!is_req) begin
      if (k == 8'h00) begin
        tx_byte = rx_frame_format_option_i ? rsr_pkg::TYPE_LOOP_RX1 : rsr_pkg::TYPE_LOOP_RX0;
      end else begin
        tx_byte = pbuf[$clog2(MAXP)'(k - 8'h01)];
      end
    end else if (k == 8'h00) begin
      tx_byte = rsr_pkg::TYPE_REMOTE_RESP;
    end else if (k == 8'h01) begin
      tx_byte = fid_r;
    end else if (k < 8'h0a) begin
      tx_byte = OWN_ADDR[8'(8'h3f - 8'((k - 8'h02) << 3)) -: 8];
    end else if (k == 8'h0a) begin
      tx_byte = rsr_pkg::RSVD_FILL[15:8];
    end else if (k == 8'h0b) begin
      tx_byte = rsr_pkg::RSVD_FILL[7:0];
    end else if (k == 8'h0c) begin
      tx_byte = cmd_r[15:8];
    end else if (k == 8'h0d) begin
      tx_byte = cmd_r[7:0];
    end else if (k == 8'h0e) begin
      tx_byte = rsr_pkg::STATUS_OK;
    end else begin
      tx_byte = set_r[idx];
    end
  end

  assign f_valid = st_r == P_SEND;

  always_ff @(posedge clk_i) begin
    if (srst_i || st_r != P_SEND) begin
      tx_idx_r <= '0;
      tx_sum_r <= '0;
    end else if (f_valid && f_ready) begin
      tx_idx_r <= tx_idx_r + 8'h01;
      if (tx_idx_r >= 8'h03) begin
        tx_sum_r <= tx_sum_r + tx_byte;
      end
    end
  end

  byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_txq (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .in_valid_i(f_valid),
    .in_ready_o(f_ready),
    .in_data_i(tx_byte),
    .out_valid_o(link.d2h_valid),
    .out_ready_i(link.d2h_ready),
    .out_data_o(link.d2h_data)
  );
endmodule

//--- core/rsr_pkg.sv
// Shared constants for the remote setting request link.
package rsr_pkg;
  localparam logic [7:0] START_DELIM = 8'h7e;
  localparam logic [7:0] TYPE_REMOTE_REQ = 8'h17;
  localparam logic [7:0] TYPE_REMOTE_RESP = 8'h97;
  localparam logic [7:0] TYPE_EXPLICIT = 8'h11;
  localparam logic [7:0] TYPE_LOOP_RX0 = 8'h90;
  localparam logic [7:0] TYPE_LOOP_RX1 = 8'h91;
  localparam logic [15:0] LOOP_CLUSTER = 16'h0012;
  localparam logic [15:0] COMMIT_CMD = 16'h4143;
  localparam logic [15:0] RSVD_FILL = 16'hfffe;
  localparam logic [7:0] SUM_BASE = 8'hff;
  localparam logic [7:0] STATUS_OK = 8'h00;
  localparam logic [7:0] OPT_LEGAL_MASK = 8'h13;
  localparam int OPT_NOACK_BIT = 0;
  localparam int OPT_APPLY_BIT = 1;
  localparam int OPT_SECURE_BIT = 4;
  localparam logic [15:0] OFS_TYPE = 16'h0003;
  localparam logic [15:0] OFS_FID = 16'h0004;
  localparam logic [15:0] OFS_OPT = 16'h000f;
  localparam logic [15:0] OFS_CMD = 16'h0010;
  localparam logic [15:0] OFS_CLUSTER = 16'h0011;
  localparam logic [15:0] OFS_STATUS = 16'h0011;
  localparam logic [15:0] OFS_PARAM = 16'h0012;
  localparam logic [15:0] OFS_PAYLOAD = 16'h0017;
  localparam logic [15:0] HDR_LEN = 16'h000f;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_FID = 8'h04;
  localparam logic [7:0] REG_DEST_HI = 8'h08;
  localparam logic [7:0] REG_DEST_LO = 8'h0c;
  localparam logic [7:0] REG_OPT = 8'h10;
  localparam logic [7:0] REG_CMD = 8'h14;
  localparam logic [7:0] REG_PARAM = 8'h18;
  localparam logic [7:0] REG_PLEN = 8'h1c;
  localparam logic [7:0] REG_STATUS = 8'h20;
  localparam logic [7:0] REG_RESP = 8'h24;
endpackage

//--- core/api_link_if.sv
// Byte stream link between the host controller and the radio device.
`timescale 1ns/1ps
interface api_link_if;
  logic [7:0] h2d_data;
  logic h2d_valid;
  logic h2d_ready;
  logic [7:0] d2h_data;
  logic d2h_valid;
  logic d2h_ready;
  modport host (output h2d_data, output h2d_valid, input h2d_ready,
                input d2h_data, input d2h_valid, output d2h_ready);
  modport device (input h2d_data, input h2d_valid, output h2d_ready,
                  output d2h_data, output d2h_valid, input d2h_ready);
endinterface

//--- core/byte_fifo.sv
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic srst_i,
  // Fill side.
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side.
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_r;
  logic [AW:0] rd_r;
  logic push;
  logic pop;

  assign in_ready_o = (wr_r - rd_r) != (AW+1)'(DEPTH);
  assign out_valid_o = wr_r != rd_r;
  assign out_data_o = mem[rd_r[AW-1:0]];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_r[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      if (push) begin
        wr_r <= wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= rd_r + 1'b1;
      end
    end
  end
endmodule

//--- core/api_host_end.sv
// Host end: builds remote setting requests from registers and collects answers.
`timescale 1ns/1ps
module api_host_end (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic srst_i,
  // Register port.
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // Status.
  output logic busy_o,
  output logic resp_valid_o,
  // Link to the device.
  api_link_if.host link
);
  logic [7:0] fid_r;
  logic [63:0] dest_r;
  logic [7:0] opt_r;
  logic [15:0] cmd_r;
  logic [31:0] param_r;
  logic [2:0] plen_r;
  logic [7:0] idx_r;
  logic [7:0] sum_r;
  logic [7:0] tx_byte;
  logic [15:0] tx_len;
  logic tx_last;
  logic [15:0] rpos_r;
  logic [15:0] rlen_r;
  logic [7:0] rsum_r;
  logic [7:0] rtype_r;
  logic [7:0] rfid_r;
  logic [7:0] rstat_r;
  logic [7:0] rdata_byte_r;
  logic [7:0] prev_r;
  logic rbad_r;
  logic rx_take;
  logic rx_done;

  assign link.h2d_valid = busy_o;
  assign link.h2d_data = tx_byte;
  assign link.d2h_ready = 1'b1;
  assign rx_take = link.d2h_valid;
  assign rx_done = rx_take && rpos_r != 16'h0000 && rpos_r == rlen_r + 16'h0003;

  ////////////////////////////////////////////////////////////////////////////////
  // Registers.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      fid_r <= '0;
      dest_r <= '0;
      opt_r <= '0;
      cmd_r <= '0;
      param_r <= '0;
      plen_r <= '0;
    end else if (wr_i && !busy_o) begin
      if (addr_i == rsr_pkg::REG_FID) begin
        fid_r <= wdata_i[7:0];
      end else if (addr_i == rsr_pkg::REG_DEST_HI) begin
        dest_r[63:32] <= wdata_i;
      end else if (addr_i == rsr_pkg::REG_DEST_LO) begin
        dest_r[31:0] <= wdata_i;
      end else if (addr_i == rsr_pkg::REG_OPT) begin
        opt_r <= wdata_i[7:0] & rsr_pkg::OPT_LEGAL_MASK;
      end else if (addr_i == rsr_pkg::REG_CMD) begin
        cmd_r <= wdata_i[15:0];
      end else if (addr_i == rsr_pkg::REG_PARAM) begin
        param_r <= wdata_i;
      end else if (addr_i == rsr_pkg::REG_PLEN) begin
        plen_r <= (wdata_i[2:0] > 3'h4) ? 3'h4 : wdata_i[2:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rdata_o <= '0;
    end else if (!rd_i) begin
      rdata_o <= '0;
    end else if (addr_i == rsr_pkg::REG_STATUS) begin
      rdata_o <= {29'h0, rbad_r, resp_valid_o, busy_o};
    end else if (addr_i == rsr_pkg::REG_RESP) begin
      rdata_o <= {rdata_byte_r, rstat_r, rfid_r, rtype_r};
    end else if (addr_i == rsr_pkg::REG_CMD) begin
      rdata_o <= {16'h0, cmd_r};
    end else begin
      rdata_o <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Request sender.
  always_comb begin
    logic [7:0] k;
    k = idx_r - 8'h03;
    tx_len = rsr_pkg::HDR_LEN + {13'h0, plen_r};
    tx_last = {8'h00, idx_r} == tx_len + 16'h0003;
    tx_byte = 8'h00;
    if (idx_r == 8'h00) begin
      tx_byte = rsr_pkg::START_DELIM;
    end else if (idx_r == 8'h01) begin
      tx_byte = tx_len[15:8];
    end else if (idx_r == 8'h02) begin
      tx_byte = tx_len[7:0];
    end else if (tx_last) begin
      tx_byte = rsr_pkg::SUM_BASE - sum_r;
    end else if (k == 8'h00) begin
      tx_byte = rsr_pkg::TYPE_REMOTE_REQ;
    end else if (k == 8'h01) begin
      tx_byte = fid_r;
    end else if (k < 8'h0a) begin
      tx_byte = dest_r[8'(8'h3f - 8'((k - 8'h02) << 3)) -: 8];
    end else if (k == 8'h0a) begin
      tx_byte = rsr_pkg::RSVD_FILL[15:8];
    end else if (k == 8'h0b) begin
      tx_byte = rsr_pkg::RSVD_FILL[7:0];
    end else if (k == 8'h0c) begin
      tx_byte = opt_r;
    end else if (k == 8'h0d) begin
      tx_byte = cmd_r[15:8];
    end else if (k == 8'h0e) begin
      tx_byte = cmd_r[7:0];
    end else begin
      tx_byte = param_r[8'(8'h1f - 8'((k - 8'h0f) << 3)) -: 8];
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      busy_o <= 1'b0;
      idx_r <= '0;
      sum_r <= '0;
    end else if (!busy_o) begin
      idx_r <= '0;
      sum_r <= '0;
      busy_o <= wr_i && addr_i == rsr_pkg::REG_CTRL && wdata_i[0];
    end else if (link.h2d_ready) begin
      idx_r <= idx_r + 8'h01;
      if (idx_r >= 8'h03) begin
        sum_r <= sum_r + tx_byte;
      end
      if (tx_last) begin
        busy_o <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Answer collector; the flag set wins over a clear in the same cycle.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rpos_r <= '0;
      rlen_r <= '0;
      rsum_r <= '0;
      rtype_r <= '0;
      rfid_r <= '0;
      rstat_r <= '0;
      rdata_byte_r <= '0;
      prev_r <= '0;
      rbad_r <= 1'b0;
      resp_valid_o <= 1'b0;
    end else begin
      if (wr_i && addr_i == rsr_pkg::REG_CTRL && wdata_i[1]) begin
        resp_valid_o <= 1'b0;
        rbad_r <= 1'b0;
      end
      if (rx_take) begin
        prev_r <= link.d2h_data;
        if (rpos_r == 16'h0000) begin
          rpos_r <= (link.d2h_data == rsr_pkg::START_DELIM) ? 16'h0001 : 16'h0000;
        end else begin
          rpos_r <= rx_done ? 16'h0000 : rpos_r + 16'h0001;
        end
        if (rpos_r == 16'h0001) begin
          rlen_r[15:8] <= link.d2h_data;
        end
        if (rpos_r == 16'h0002) begin
          rlen_r[7:0] <= link.d2h_data;
          rsum_r <= '0;
        end
        if (rpos_r >= rsr_pkg::OFS_TYPE && !rx_done) begin
          rsum_r <= rsum_r + link.d2h_data;
        end
        if (rpos_r == rsr_pkg::OFS_TYPE) begin
          rtype_r <= link.d2h_data;
        end
        if (rpos_r == rsr_pkg::OFS_FID) begin
          rfid_r <= link.d2h_data;
        end
        if (rpos_r == rsr_pkg::OFS_STATUS) begin
          rstat_r <= link.d2h_data;
        end
        if (rx_done) begin
          rdata_byte_r <= prev_r;
          if (8'(rsum_r + link.d2h_data) == rsr_pkg::SUM_BASE) begin
            resp_valid_o <= 1'b1;
          end else begin
            rbad_r <= 1'b1;
          end
        end
      end
    end
  end
endmodule

//--- sim/rsr_link_asserts.sv
// Checks on frames crossing the link between host end and device end.
`timescale 1ns/1ps
module rsr_link_asserts (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic srst_i,
  // Link.
  input wire logic [7:0] h2d_data,
  input wire logic h2d_valid,
  input wire logic h2d_ready,
  input wire logic [7:0] d2h_data,
  input wire logic d2h_valid,
  input wire logic d2h_ready
);
  //////////////////////////////////////////////////
  // Byte counters tell each check which field is on the wire.
  logic [15:0] hi_r, hlen_r, di_r, dlen_r;
  logic [7:0] hsum_r, fid_r;
  wire th = h2d_valid && h2d_ready;
  wire td = d2h_valid && d2h_ready;
  wire hend = th && hi_r > 16'h0002 && hi_r == hlen_r + 16'h0003;
  wire dend = td && di_r > 16'h0002 && di_r == dlen_r + 16'h0003;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      hi_r <= 16'h0000;
      hlen_r <= 16'h0000;
      hsum_r <= 8'h00;
      fid_r <= 8'h00;
    end else if (th) begin
      hi_r <= hend ? 16'h0000 : hi_r + 16'h0001;
      hlen_r <= (hi_r < 16'h0003) ? {hlen_r[7:0], h2d_data} : hlen_r;
      hsum_r <= (hi_r < 16'h0003) ? 8'h00 : hsum_r + h2d_data;
      fid_r <= (hi_r == 16'h0004) ? h2d_data : fid_r;
    end
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      di_r <= 16'h0000;
      dlen_r <= 16'h0000;
    end else if (td) begin
      di_r <= dend ? 16'h0000 : di_r + 16'h0001;
      dlen_r <= (di_r < 16'h0003) ? {dlen_r[7:0], d2h_data} : dlen_r;
    end
  end
  //////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  sequence s_req_end;
    hend;
  endsequence
  property p_hold; h2d_valid && !h2d_ready |=> h2d_valid && $stable(h2d_data); endproperty
  a_hold: assert property (p_hold) else $error("request byte withdrawn");
  property p_hdelim; th && hi_r == 16'h0000 |-> h2d_data == rsr_pkg::START_DELIM; endproperty
  a_hdelim: assert property (p_hdelim) else $error("bad delimiter");
  property p_htype; th && hi_r == 16'h0003 |-> h2d_data == rsr_pkg::TYPE_REMOTE_REQ; endproperty
  a_htype: assert property (p_htype) else $error("bad request type");
  property p_rsvd; th && hi_r == 16'h000d |-> h2d_data == rsr_pkg::RSVD_FILL[15:8]; endproperty
  a_rsvd: assert property (p_rsvd) else $error("bad reserved fill");
  property p_hsum; hend |-> h2d_data == rsr_pkg::SUM_BASE - hsum_r; endproperty
  a_hsum: assert property (p_hsum) else $error("bad request checksum");
  property p_dtype; td && di_r == 16'h0003 |-> d2h_data == rsr_pkg::TYPE_REMOTE_RESP; endproperty
  a_dtype: assert property (p_dtype) else $error("bad answer type");
  property p_fid; td && di_r == 16'h0004 |-> d2h_data == fid_r; endproperty
  a_fid: assert property (p_fid) else $error("answer id differs");
  property p_quiet; s_req_end ##0 (fid_r == 8'h00) |=> !d2h_valid [*8]; endproperty
  a_quiet: assert property (p_quiet) else $error("answer to id zero");
endmodule

//--- sim/remote_setting_request_frames_tb.sv
// Bench for host end and device end, with a raw driver on a second device.
`timescale 1ns/1ps
module remote_setting_request_frames_tb;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic rd_d = 1'b0;
  logic fmt = 1'b0;
  logic [31:0] rdata_o, setting_o;
  logic busy_o, resp_valid_o, ack_disable_o, secure_o, req_done_o, bad2;
  logic [31:0] exp_q[$];
  logic [7:0] lq[$];
  int err_count = 0;
  int comparisons = 0;
  int cyc = 0;
  int nbad = 0, ndone = 0;
  api_link_if link();
  api_link_if link2();
  api_host_end api_host_end_inst (.clk_i, .srst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .busy_o, .resp_valid_o, .link(link.host));
  api_device_end api_device_end_inst (.clk_i, .srst_i, .link(link.device),
    .rx_frame_format_option_i(fmt), .setting_o, .ack_disable_o, .secure_o, .req_done_o,
    .bad_frame_o());
  api_device_end api_device_end_inst2 (.clk_i, .srst_i, .link(link2.device),
    .rx_frame_format_option_i(fmt), .setting_o(), .ack_disable_o(), .secure_o(),
    .req_done_o(), .bad_frame_o(bad2));
  rsr_link_asserts rsr_link_asserts_inst (.clk_i, .srst_i, .h2d_data(link.h2d_data),
    .h2d_valid(link.h2d_valid), .h2d_ready(link.h2d_ready), .d2h_data(link.d2h_data),
    .d2h_valid(link.d2h_valid), .d2h_ready(link.d2h_ready));
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  //////////////////////////////////////////////////
  task automatic end_of_test;
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  // Reads and loopback bytes are judged here, in the order they were noted.
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    rd_d <= rd_i;
    if (rd_d) chk("rdata", exp_q.pop_front(), rdata_o);
    if (bad2 === 1'b1) nbad++;
    if (req_done_o === 1'b1) ndone++;
    if (link2.d2h_valid === 1'b1) begin
      chk("loop", lq.size() ? lq.pop_front() : 32'hbad, link2.d2h_data);
    end
    if (cyc == 20000) begin
      err_count++;
      end_of_test();
    end
  end
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= w;
    rd_i <= !w;
    if (!w) exp_q.push_back(d);
    @(posedge clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
  endtask
  task automatic req(input logic [7:0] f, o, input logic [15:0] c, input logic [7:0] v,
                     input logic [2:0] n);
    bus(1, rsr_pkg::REG_CTRL, 32'h2);
    bus(1, rsr_pkg::REG_FID, {24'h0, f});
    bus(1, rsr_pkg::REG_DEST_HI, $urandom | 32'h1);
    bus(1, rsr_pkg::REG_DEST_LO, $urandom);
    bus(1, rsr_pkg::REG_OPT, {24'h0, o});
    bus(1, rsr_pkg::REG_CMD, {16'h0, c});
    bus(1, rsr_pkg::REG_PARAM, {v, 24'h0});
    bus(1, rsr_pkg::REG_PLEN, {29'h0, n});
    bus(1, rsr_pkg::REG_CTRL, 32'h1);
    @(posedge clk_i);
    for (int i = 0; i < 99 && busy_o !== 1'b0; i++) @(posedge clk_i);
    for (int i = 0; i < 60 && resp_valid_o !== 1'b1; i++) @(posedge clk_i);
  endtask
  task automatic raw(input logic [7:0] x);
    link2.h2d_data <= x;
    link2.h2d_valid <= 1'b1;
    @(posedge clk_i);
    for (int i = 0; i < 99 && link2.h2d_ready !== 1'b1; i++) @(posedge clk_i);
  endtask
  task automatic frame(input logic [7:0] b[$], input logic [7:0] spoil);
    logic [7:0] s;
    s = 8'hff;
    raw(8'h7e);
    raw(8'h00);
    raw(8'(b.size()));
    foreach (b[i]) begin
      s -= b[i];
      raw(b[i]);
    end
    raw(s ^ spoil);
    link2.h2d_valid <= 1'b0;
    link2.h2d_data <= ~s;
  endtask
  //////////////////////////////////////////////////
  initial begin
    logic [7:0] f, v, w, s, t, p;
    logic [7:0] b[$], hd[$];
    logic [15:0] c;
    int k;
    link2.h2d_data = 8'h00;
    link2.h2d_valid = 1'b0;
    link2.d2h_ready = 1'b1;
    void'($urandom(34));
    repeat (20) @(posedge clk_i);
    srst_i <= 1'b0;
    f = 8'h01 + 8'($urandom % 254);
    v = 8'($urandom);
    w = ~v;
    k = $urandom % 4;
    c = {8'h4e, 8'h30 + 8'(k)};
    req(f, 8'h13, c, v, 3'h1);
    chk("setting", {24'h0, v}, setting_o[8*k+:8]);
    chk("noack", 1, ack_disable_o);
    chk("secure", 1, secure_o);
    bus(0, rsr_pkg::REG_RESP, {16'h0, f, rsr_pkg::TYPE_REMOTE_RESP});
    $display("apply done");
    req(f, 8'h00, c, w, 3'h1);
    chk("pending", {24'h0, v}, setting_o[8*k+:8]);
    chk("ack", 0, ack_disable_o);
    chk("plain", 0, secure_o);
    req(f, 8'h02, {8'h4e, 8'h30 + 8'((k + 1) % 4)}, v, 3'h1);
    chk("applied", {24'h0, w}, setting_o[8*k+:8]);
    $display("pending done");
    req(f, 8'h00, c, 8'h00, 3'h0);
    bus(0, rsr_pkg::REG_RESP, {w, 8'h00, f, rsr_pkg::TYPE_REMOTE_RESP});
    req(8'h00, 8'h02, c, v, 3'h1);
    chk("silent", {24'h0, v}, setting_o[8*k+:8]);
    chk("done", 5, ndone);
    bus(0, rsr_pkg::REG_STATUS, 32'h0);
    bus(0, 8'h30, 32'h0);
    $display("query done");
    hd = {8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'hff, 8'hfe};
    b = {rsr_pkg::TYPE_REMOTE_REQ, 8'h33, hd, 8'h00, 8'h4e, 8'h30};
    frame(b, 8'h01);
    repeat (30) @(posedge clk_i);
    chk("bad", 1, nbad);
    for (int m = 0; m < 2; m++) begin
      fmt <= m[0];
      t = m ? rsr_pkg::TYPE_LOOP_RX1 : rsr_pkg::TYPE_LOOP_RX0;
      b = {8'h11, 8'h01, hd, 8'he8, 8'he8, 8'h00, 8'h12, 8'h00, 8'h00, 8'h00, 8'h01};
      lq = {8'h7e, 8'h00, 8'h04, t};
      s = 8'hff - t;
      for (int j = 0; j < 3; j++) begin
        p = 8'($urandom);
        b.push_back(p);
        lq.push_back(p);
        s -= p;
      end
      lq.push_back(s);
      frame(b, 8'h00);
      for (int i = 0; i < 99 && lq.size() > 0; i++) @(posedge clk_i);
      chk("left", 0, lq.size());
    end
    $display("link done");
    repeat (5) @(posedge clk_i);
    end_of_test();
  end
endmodule
